//--- test/pfr_flags_tb_top.sv
`timescale 1ns/1ps
module pfr_flags_tb_top
  import pfr_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        por_reset = 1'b1;
  logic        bor_reset = 1'b0;
  logic [3:0]  src = '0;
  logic [1:0]  ccp = '0;
  logic        cmp2 = 1'b0;
  logic        cmp1 = 1'b0;
  logic [1:0]  mode = CCP_OFF;
  logic [1:0]  cfg = 2'h0;
  logic        wake_en, bor_en, irq;
  logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  exp, d;
  int          fails = 0, checks = 0, i;

  pfr_flags dut (.clock, .rst, .por_reset, .bor_reset, .osc_failed(src[0]),
    .comparator_two_output(cmp2), .comparator_one_output(cmp1), .nv_write_done(src[1]),
    .bus_collision(src[2]), .lowpower_wake_event(src[3]), .capcmp_mode(mode),
    .capture_event(ccp[0]), .compare_match(ccp[1]), .brownout_config_select(cfg),
    .lowpower_wake_enable(wake_en), .brownout_detect_enable(bor_en), .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // Free-running clock
  always #5 clock = ~clock;

  task chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // Write one byte; waits for the response with no fixed latency
  task wr(input logic [3:0] a, input logic [7:0] v, input logic [3:0] s);
    logic ta, tw, tb;
    logic [1:0] rsp;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  // Read a register and compare its low byte, upper bits zero
  task rchk(input logic [3:0] a, input logic [7:0] want);
    logic ta, tr;
    logic [31:0] v;
    logic [1:0] rr;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clock);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      v = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(v, {24'h0, want});
    chk({30'h0, rr}, {30'h0, RESP_OKAY});
  endtask

  // One source event: 0-3 pulses, 4-5 comparator toggles, 6-7 capture/compare
  task fire(input int k);
    @(posedge clock);
    if (k < 4) src[k] <= 1'b1;
    else if (k == 4) cmp2 <= !cmp2;
    else if (k == 5) cmp1 <= !cmp1;
    else ccp[k-6] <= 1'b1;
    @(posedge clock);
    src <= '0;
    ccp <= '0;
    repeat (3) @(posedge clock);
  endtask

  function automatic logic [7:0] bit_of(int k);
    int p[6] = '{FLG_OSC, FLG_NVW, FLG_BCOL, FLG_WAKE, FLG_CMP2, FLG_CMP1};
    return 8'h01 << p[k];
  endfunction

  task end_of_test;
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    end_of_test;
  end

  // Main sequence
  initial begin
    void'($urandom(32'h7bf4));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    por_reset <= 1'b0;
    rchk(PFR_FLAGS_OFF, FLAGS_RESET);
    rchk(PFR_PWR_OFF, PWR_POR_RESET);
    exp = 8'h00;
    for (int k = 0; k < 14; k++) begin
      i = (k < 6) ? k : int'($urandom % 6);
      fire(i);
      exp = exp | bit_of(i);
      rchk(PFR_FLAGS_OFF, exp);
    end
    wr(PFR_FLAGS_OFF, 8'h00, 4'hf);
    rchk(PFR_FLAGS_OFF, 8'h00);
    wr(PFR_FLAGS_OFF, 8'hff, 4'h0);
    rchk(PFR_FLAGS_OFF, 8'h00);
    wr(PFR_FLAGS_OFF, 8'hff, 4'hf);
    rchk(PFR_FLAGS_OFF, FLAGS_IMPL);
    // Capture/compare flag per mode
    for (int m = 0; m < 4; m++) begin
      for (int j = 6; j < 8; j++) begin
        wr(PFR_FLAGS_OFF, 8'h00, 4'hf);
        mode <= m[1:0];
        fire(j);
        exp = ((m == 1 && j == 6) || (m == 2 && j == 7)) ? 8'h01 : 8'h00;
        rchk(PFR_FLAGS_OFF, exp);
      end
    end
    // Interrupt raised, masked and cleared
    wr(PFR_IRQ_ST_OFF, 8'hff, 4'hf);
    wr(PFR_IRQ_MK_OFF, 8'h80, 4'hf);
    @(negedge clock);
    chk(irq, 1'b0);
    fire(0);
    fire(1);
    @(negedge clock);
    chk(irq, 1'b1);
    wr(PFR_IRQ_ST_OFF, 8'h80, 4'hf);
    rchk(PFR_IRQ_ST_OFF, 8'h10);
    @(negedge clock);
    chk(irq, 1'b0);
    // Power register fields and brown-out select
    for (int c = 0; c < 4; c++) begin
      d = 8'($urandom);
      d[4] = c[0];
      cfg <= c[1:0];
      wr(PFR_PWR_OFF, d, 4'hf);
      rchk(PFR_PWR_OFF, d & PWR_IMPL);
      @(negedge clock);
      chk(bor_en, (c == 1) ? d[4] : 1'b0);
      chk(wake_en, d[5]);
    end
    // Brown-out then power-on reset in mid-run
    wr(PFR_PWR_OFF, 8'h33, 4'hf);
    fire(2);
    @(posedge clock);
    rst <= 1'b1;
    bor_reset <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bor_reset <= 1'b0;
    rchk(PFR_PWR_OFF, 8'h12);
    chk(wake_en, 1'b0);
    rchk(PFR_FLAGS_OFF, 8'h00);
    @(posedge clock);
    rst <= 1'b1;
    por_reset <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    por_reset <= 1'b0;
    rchk(PFR_PWR_OFF, PWR_POR_RESET);
    end_of_test;
  end
endmodule

//--- verilog/pfr_flags.sv
`timescale 1ns/1ps
module pfr_flags
  import pfr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        por_reset,
  input  wire logic        bor_reset,
  input  wire logic        osc_failed,
  input  wire logic        comparator_two_output,
  input  wire logic        comparator_one_output,
  input  wire logic        nv_write_done,
  input  wire logic        bus_collision,
  input  wire logic        lowpower_wake_event,
  input  wire logic [1:0]  capcmp_mode,
  input  wire logic        capture_event,
  input  wire logic        compare_match,
  input  wire logic [1:0]  brownout_config_select,
  output logic             lowpower_wake_enable,
  output logic             brownout_detect_enable,
  output logic             irq,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  logic [7:0]  flags_r;
  logic [7:0]  pwr_r;
  logic [7:0]  irq_st_r;
  logic [7:0]  irq_mk_r;
  logic        cmp2_prev_r;
  logic        cmp1_prev_r;
  logic        cmp_seen_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [3:0]  aw_addr_r;
  logic [7:0]  w_data_r;
  logic        w_strb0_r;
  logic [7:0]  hw_set;
  logic        wr_fire;
  logic        wr_lane;
  logic        wr_flags;
  logic        wr_pwr;
  logic        wr_st;
  logic        wr_mk;
  logic [7:0]  rd_val;
  logic        rd_ok;

  // Write address and data taken independently
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign wr_fire  = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_lane  = wr_fire && w_strb0_r;
  assign wr_flags = wr_lane && (aw_addr_r == PFR_FLAGS_OFF);
  assign wr_pwr   = wr_lane && (aw_addr_r == PFR_PWR_OFF);
  assign wr_st    = wr_lane && (aw_addr_r == PFR_IRQ_ST_OFF);
  assign wr_mk    = wr_lane && (aw_addr_r == PFR_IRQ_MK_OFF);

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r  <= 8'h00;
      w_strb0_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
      end else if (wr_fire) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r   <= 1'b1;
        w_data_r  <= s_axi_wdata[7:0];
        w_strb0_r <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // Write response, error on unmapped offset
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_r[3:0] <= PFR_IRQ_MK_OFF) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Hardware set terms for each flag
  always_comb begin
    hw_set = 8'h00;
    hw_set[FLG_OSC]  = osc_failed;
    hw_set[FLG_CMP2] = cmp_seen_r && (comparator_two_output != cmp2_prev_r);
    hw_set[FLG_CMP1] = cmp_seen_r && (comparator_one_output != cmp1_prev_r);
    hw_set[FLG_NVW]  = nv_write_done;
    hw_set[FLG_BCOL] = bus_collision;
    hw_set[FLG_WAKE] = lowpower_wake_event;
    hw_set[FLG_CCP2] = ((capcmp_mode == CCP_CAPTURE) && capture_event)
                    || ((capcmp_mode == CCP_COMPARE) && compare_match);
  end

  // Comparator output history for change detection
  always_ff @(posedge clock) begin
    if (rst) begin
      cmp2_prev_r <= 1'b0;
      cmp1_prev_r <= 1'b0;
      cmp_seen_r  <= 1'b0;
    end else begin
      cmp2_prev_r <= comparator_two_output;
      cmp1_prev_r <= comparator_one_output;
      cmp_seen_r  <= 1'b1;
    end
  end

  // Sticky flags: set wins over software write
  always_ff @(posedge clock) begin
    if (rst) begin
      flags_r <= FLAGS_RESET;
    end else if (wr_flags) begin
      flags_r <= (w_data_r | hw_set) & FLAGS_IMPL;
    end else begin
      flags_r <= flags_r | (hw_set & FLAGS_IMPL);
    end
  end

  // Power control and reset status
  always_ff @(posedge clock) begin
    if (por_reset) begin
      pwr_r <= PWR_POR_RESET;
    end else begin
      if (rst) begin
        pwr_r[PWR_WAKE_EN] <= 1'b0;
        pwr_r[PWR_SBOR]    <= 1'b1;
      end else if (wr_pwr) begin
        pwr_r[PWR_WAKE_EN] <= w_data_r[PWR_WAKE_EN];
        pwr_r[PWR_SBOR]    <= w_data_r[PWR_SBOR];
        pwr_r[PWR_POR]     <= w_data_r[PWR_POR];
      end
      if (bor_reset) begin
        pwr_r[PWR_BOR] <= 1'b0;
      end else if (wr_pwr) begin
        pwr_r[PWR_BOR] <= w_data_r[PWR_BOR];
      end
    end
  end

  assign lowpower_wake_enable   = pwr_r[PWR_WAKE_EN];
  assign brownout_detect_enable = (brownout_config_select == BOR_SEL_SOFT) ?
                                  pwr_r[PWR_SBOR] : 1'b0;

  // Interrupt status: hardware set terms set, write one clears
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_st_r <= 8'h00;
      irq_mk_r <= 8'h00;
    end else begin
      irq_st_r <= (irq_st_r & ~(wr_st ? w_data_r : 8'h00)) | (hw_set & FLAGS_IMPL);
      if (wr_mk) begin
        irq_mk_r <= w_data_r & FLAGS_IMPL;
      end
    end
  end

  assign irq = |(irq_st_r & irq_mk_r);

  // Read path
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 8'h00;
    unique case ({s_axi_araddr[3:2], 2'b00})
      PFR_FLAGS_OFF:  rd_val = flags_r & FLAGS_IMPL;
      PFR_PWR_OFF:    rd_val = pwr_r & PWR_IMPL;
      PFR_IRQ_ST_OFF: rd_val = irq_st_r;
      PFR_IRQ_MK_OFF: rd_val = irq_mk_r;
      default:        rd_ok  = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_val};
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  flag_hold_a: assert property (@(posedge clock) disable iff (rst)
    flags_r[FLG_OSC] && !wr_flags |=> flags_r[FLG_OSC])
    else $error("osc flag cleared without write");
  osc_set_a: assert property (@(posedge clock) disable iff (rst)
    osc_failed |=> flags_r[FLG_OSC]) else $error("osc flag not set");
  cmp2_set_a: assert property (@(posedge clock) disable iff (rst)
    cmp_seen_r && $changed(comparator_two_output) |-> ##1 flags_r[FLG_CMP2])
    else $error("cmp2 flag not set");
  cmp1_set_a: assert property (@(posedge clock) disable iff (rst)
    cmp_seen_r && $changed(comparator_one_output) |-> ##1 flags_r[FLG_CMP1])
    else $error("cmp1 flag not set");
  nvw_set_a: assert property (@(posedge clock) disable iff (rst)
    nv_write_done |=> flags_r[FLG_NVW]) else $error("nv flag not set");
  bcol_set_a: assert property (@(posedge clock) disable iff (rst)
    bus_collision |=> flags_r[FLG_BCOL]) else $error("collision flag not set");
  wake_set_a: assert property (@(posedge clock) disable iff (rst)
    lowpower_wake_event |=> flags_r[FLG_WAKE]) else $error("wake flag not set");
  ccp_cap_a: assert property (@(posedge clock) disable iff (rst)
    capcmp_mode == CCP_CAPTURE && capture_event |=> flags_r[FLG_CCP2])
    else $error("capture flag not set");
  ccp_pwm_a: assert property (@(posedge clock) disable iff (rst)
    capcmp_mode == CCP_PWM && !flags_r[FLG_CCP2] && !wr_flags |=> !flags_r[FLG_CCP2])
    else $error("pwm set capcmp flag");
  bor_sel_a: assert property (@(posedge clock)
    brownout_config_select != BOR_SEL_SOFT |-> !brownout_detect_enable)
    else $error("soft brownout active wrongly");
  unimpl_zero_a: assert property (@(posedge clock) disable iff (rst)
    !flags_r[1] && (pwr_r & ~PWR_IMPL) == 8'h00) else $error("unimplemented bit set");
  por_clear_a: assert property (@(posedge clock)
    por_reset |=> !pwr_r[PWR_POR]) else $error("power-on bit not cleared");
  bor_clear_a: assert property (@(posedge clock) disable iff (por_reset)
    bor_reset |=> !pwr_r[PWR_BOR]) else $error("brown-out bit not cleared");

  // Steps of a software clear and of a comparator change
  sequence flag_clear_s;
    wr_flags && !w_data_r[FLG_OSC] && !osc_failed;
  endsequence
  sequence cmp_change_s;
    cmp_seen_r && ($changed(comparator_two_output) || $changed(comparator_one_output));
  endsequence
  // Whole-register hold, clear, idle and interrupt checks
  flags_keep_a: assert property (@(posedge clock) disable iff (rst)
    !wr_flags |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag cleared without write");
  osc_clear_a: assert property (@(posedge clock) disable iff (rst)
    flag_clear_s |=> !flags_r[FLG_OSC])
    else $error("osc flag not cleared by write");
  cmp_any_a: assert property (@(posedge clock) disable iff (rst)
    cmp_change_s |=> |flags_r[FLG_CMP2:FLG_CMP1])
    else $error("comparator change lost");
  ccp_cmp_a: assert property (@(posedge clock) disable iff (rst)
    capcmp_mode == CCP_COMPARE && compare_match |=> flags_r[FLG_CCP2])
    else $error("compare flag not set");
  ccp_off_a: assert property (@(posedge clock) disable iff (rst)
    capcmp_mode == CCP_OFF && !flags_r[FLG_CCP2] && !wr_flags |=> !flags_r[FLG_CCP2])
    else $error("idle unit set capcmp flag");
  nvw_idle_a: assert property (@(posedge clock) disable iff (rst)
    !nv_write_done && !flags_r[FLG_NVW] && !wr_flags |=> !flags_r[FLG_NVW])
    else $error("nv flag set with no write done");
  wake_rst_a: assert property (@(posedge clock)
    rst |=> !lowpower_wake_enable && pwr_r[PWR_SBOR])
    else $error("power enables not reset");
  por_keep_a: assert property (@(posedge clock)
    !pwr_r[PWR_POR] && !wr_pwr |=> !pwr_r[PWR_POR])
    else $error("power-on bit set by hardware");
  bor_keep_a: assert property (@(posedge clock)
    !pwr_r[PWR_BOR] && !wr_pwr |=> !pwr_r[PWR_BOR])
    else $error("brown-out bit set by hardware");
  irq_set_a: assert property (@(posedge clock) disable iff (rst)
    osc_failed |=> irq_st_r[FLG_OSC])
    else $error("status bit not set");
  irq_out_a: assert property (@(posedge clock) disable iff (rst)
    irq_st_r[FLG_OSC] && irq_mk_r[FLG_OSC] |-> irq)
    else $error("interrupt not raised");

endmodule

//--- verilog/pfr_pkg.sv
package pfr_pkg;
  // Register byte offsets
  localparam logic [3:0] PFR_FLAGS_OFF  = 4'h0;
  localparam logic [3:0] PFR_PWR_OFF    = 4'h4;
  localparam logic [3:0] PFR_IRQ_ST_OFF = 4'h8;
  localparam logic [3:0] PFR_IRQ_MK_OFF = 4'hc;
  // Flag register bit positions
  localparam int FLG_OSC  = 7;
  localparam int FLG_CMP2 = 6;
  localparam int FLG_CMP1 = 5;
  localparam int FLG_NVW  = 4;
  localparam int FLG_BCOL = 3;
  localparam int FLG_WAKE = 2;
  localparam int FLG_CCP2 = 0;
  localparam logic [7:0] FLAGS_IMPL  = 8'hfd;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // Power control bit positions
  localparam int PWR_WAKE_EN = 5;
  localparam int PWR_SBOR    = 4;
  localparam int PWR_POR     = 1;
  localparam int PWR_BOR     = 0;
  localparam logic [7:0] PWR_IMPL = 8'h33;
  localparam logic [7:0] PWR_POR_RESET = 8'h10;
  localparam logic [1:0] BOR_SEL_SOFT = 2'h1;
  // Capture/compare unit modes
  localparam logic [1:0] CCP_OFF     = 2'h0;
  localparam logic [1:0] CCP_CAPTURE = 2'h1;
  localparam logic [1:0] CCP_COMPARE = 2'h2;
  localparam logic [1:0] CCP_PWM     = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
